// file: dv/pmp_req_model.sv
// Requester model: CPU and system masters presenting accesses to the block
`timescale 1ns/1ps
module pmp_req_model (
  input wire logic clk_i,
  output logic req_valid_o,
  output logic [31:0] req_addr_o,
  output pmp_pkg::pmp_kind_t req_kind_o,
  output pmp_pkg::pmp_src_t req_src_o,
  output logic req_sup_o,
  input wire logic acc_valid_i,
  input wire logic acc_grant_i,
  input wire logic acc_deny_i
);
  import pmp_pkg::*;
  // Idle at time zero
  initial begin
    req_valid_o = 1'b0;
    req_addr_o = 32'h0;
    req_kind_o = PMP_READ;
    req_src_o = PMP_SRC_CPU;
    req_sup_o = 1'b0;
  end
  // Present one access for one edge, return valid, grant and deny
  task automatic issue(input logic [31:0] a, input pmp_kind_t k, input pmp_src_t s,
    input logic sup, output logic [2:0] v);
    @(posedge clk_i);
    req_valid_o <= 1'b1;
    req_addr_o <= a;
    req_kind_o <= k;
    req_sup_o <= sup;
    // source code says CPU (ID 0) or other master
    req_src_o <= s;
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    // Released address shows the inverse, not a stale copy
    req_addr_o <= ~a;
    #1;
    v = {acc_valid_i, acc_grant_i, acc_deny_i};
  endtask : issue
endmodule : pmp_req_model

// file: dv/testbench.sv
// Self-checking bench for the page memory protection block
`timescale 1ns/1ps
module testbench;
  import pmp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [WB_ADR_W-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, req_valid_i, req_sup_i, acc_valid_o, acc_grant_o, acc_deny_o, irq_o;
  logic [31:0] req_addr_i;
  pmp_kind_t req_kind_i;
  pmp_src_t req_src_i;
  int n_fail = 0;
  int check_count = 0;
  always #2 clk_i = ~clk_i;
  pmp_top pmp_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_valid_i(req_valid_i),
    .req_addr_i(req_addr_i), .req_kind_i(req_kind_i), .req_src_i(req_src_i),
    .req_sup_i(req_sup_i), .acc_valid_o(acc_valid_o), .acc_grant_o(acc_grant_o),
    .acc_deny_o(acc_deny_o), .irq_o(irq_o));
  pmp_req_model pmp_req_model_i (.clk_i(clk_i), .req_valid_o(req_valid_i),
    .req_addr_o(req_addr_i), .req_kind_o(req_kind_i), .req_src_o(req_src_i),
    .req_sup_o(req_sup_i), .acc_valid_i(acc_valid_o), .acc_grant_i(acc_grant_o),
    .acc_deny_i(acc_deny_o));
  // Closing report and end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  // Compare with case equality, count and report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One classic Wishbone cycle, bounded wait for ack
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n == 20) begin
      chk("ack wait", 32'h1, 32'h0);
      print_verdict();
    end
  endtask : wb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk("read data", e, r);
  endtask : rd
  // One access through the model, judged on grant or deny
  task automatic acc(input logic [31:0] a, input int k, input int s, input logic sup,
    input logic g);
    logic [2:0] v;
    pmp_req_model_i.issue(a, pmp_kind_t'(k), pmp_src_t'(s), sup, v);
    chk("verdict", {29'h0, 1'b1, g, ~g}, {29'h0, v});
  endtask : acc
  // Reset values, unmapped places and byte lanes
  task automatic t_regs();
    rd(REG_L2_ATTR, 32'h3FF);
    rd(REG_L1D_ATTR + 12'h07C, 32'h3FF);
    rd(REG_STATUS, 32'h0);
    wr(12'h100, 32'h0);
    rd(12'h100, 32'h0);
    rd(12'h3F0, 32'h0);
    // Byte lanes: lane 0 only on an attribute, lane 1 only on the mask
    wb_sel_i <= 4'h1;
    wr(REG_L2_ATTR + 12'h004, 32'h0);
    wb_sel_i <= 4'h2;
    wr(REG_MASK, 32'h3);
    wb_sel_i <= 4'hF;
    rd(REG_L2_ATTR + 12'h004, 32'h300);
    rd(REG_MASK, 32'h0);
    wr(REG_L2_ATTR + 12'h004, 32'h3FF);
    $display("test regs done");
  endtask : t_regs
  // First and last page of each memory closed, neighbours open
  task automatic t_pages();
    logic [11:0] rb[3] = '{12'h000, 12'h100, 12'h200};
    int fi[3] = '{0, 16, 16};
    logic [31:0] mb[3] = '{L2_BASE, L1D_BASE, L1P_BASE};
    logic [31:0] ps[3] = '{32'h20000, 32'h800, 32'h800};
    int np[3] = '{32, 16, 16};
    logic [31:0] top;
    for (int m = 0; m < 3; m++) begin
      top = mb[m] + np[m] * ps[m];
      wr(rb[m] + 12'(4 * fi[m]), 32'h0);
      wr(rb[m] + 12'(4 * (fi[m] + np[m] - 1)), 32'h0);
      acc(mb[m], 0, 0, 1'b1, 1'b0);
      acc(mb[m] + ps[m] - 1, 1, 1, 1'b1, 1'b0);
      acc(mb[m] + ps[m], 0, 0, 1'b1, 1'b1);
      acc(top - ps[m], 2, 0, 1'b1, 1'b0);
      acc(top - 1, 0, 3, 1'b0, 1'b0);
      acc(top, 0, 0, 1'b0, 1'b1);
      acc(mb[m] - 1, 1, 2, 1'b0, 1'b1);
      wr(rb[m] + 12'(4 * fi[m]), 32'h3FF);
      wr(rb[m] + 12'(4 * (fi[m] + np[m] - 1)), 32'h3FF);
    end
    rd(REG_STATUS, 32'h3);
    $display("test pages done");
  endtask : t_pages
  // Each mode bit closes only its own kind and mode
  task automatic t_mode();
    for (int b = 0; b < 6; b++) begin
      wr(REG_L2_ATTR + 12'h014, 32'h3FF & ~(32'h1 << b));
      for (int k = 0; k < 6; k++) begin
        acc(32'h008A0040, (k % 3 == 0) ? 2 : (k % 3 == 1) ? 1 : 0, 0, k >= 3, k != b);
      end
    end
    wr(REG_L2_ATTR + 12'h014, 32'h3FF);
    rd(REG_STATUS, 32'h1);
    $display("test mode bits done");
  endtask : t_mode
  // Local, global and privilege allow bits against every source
  task automatic t_route();
    for (int b = 6; b < 10; b++) begin
      wr(REG_L2_ATTR + 12'h008, 32'h3FF & ~(32'h1 << b));
      for (int s = 0; s < 4; s++) begin
        acc(32'h00840100, 0, s, 1'b1, (s == 0) ? (b % 2 == 1) : (b % 2 == 0));
      end
    end
    wr(REG_L2_ATTR + 12'h008, 32'h3FF);
    rd(REG_STATUS, 32'h3);
    $display("test routing done");
  endtask : t_route
  // Denial flags, fault record, masked interrupt, read clear
  task automatic t_fault();
    wr(REG_MASK, 32'h3);
    rd(REG_MASK, 32'h3);
    wr(REG_L2_ATTR + 12'h00C, 32'h0);
    acc(32'h00860010, 0, 0, 1'b0, 1'b0);
    chk("irq", 32'h1, {31'h0, irq_o});
    rd(REG_FAULT_ADDR, 32'h00860010);
    rd(REG_FAULT_INFO, 32'h0);
    acc(32'h00860020, 1, 1, 1'b1, 1'b0);
    rd(REG_FAULT_INFO, 32'h15);
    rd(REG_STATUS, 32'h3);
    #1;
    chk("irq", 32'h0, {31'h0, irq_o});
    rd(REG_STATUS, 32'h0);
    acc(32'h01000000, 1, 0, 1'b0, 1'b1);
    wr(REG_MASK, 32'h2);
    acc(32'h00860030, 2, 0, 1'b1, 1'b0);
    chk("irq", 32'h0, {31'h0, irq_o});
    rd(REG_STATUS, 32'h1);
    wr(REG_L2_ATTR + 12'h00C, 32'h3FF);
    $display("test fault done");
  endtask : t_fault
  // Mid-run reset returns attributes and mask to their reset values
  task automatic t_reset();
    wr(REG_L2_ATTR + 12'h010, 32'h0);
    wr(REG_MASK, 32'h1);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(REG_L2_ATTR + 12'h010, 32'h3FF);
    rd(REG_MASK, 32'h0);
    acc(32'h00880000, 0, 0, 1'b0, 1'b1);
    $display("test reset done");
  endtask : t_reset
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_pages();
    t_mode();
    t_route();
    t_fault();
    t_reset();
    print_verdict();
  end
endmodule : testbench

// file: rtl/pmp_chk_if.sv
// Bundle between the block and its page permission checker
`timescale 1ns/1ps
interface pmp_chk_if;
  import pmp_pkg::*;
  logic [ATTR_W-1:0] attr; // Attribute word of the page
  pmp_kind_t kind; // Access kind
  logic sup; // Supervisor mode
  logic is_local; // Local access
  logic priv; // Privilege ID
  logic allow; // Verdict
  modport ctl (output attr, kind, sup, is_local, priv, input allow);
  modport chk (input attr, kind, sup, is_local, priv, output allow);
endinterface : pmp_chk_if

// file: rtl/pmp_page_check.sv
// Permission check of one access against one attribute word
`timescale 1ns/1ps
module pmp_page_check (
  pmp_chk_if.chk c
);
  import pmp_pkg::*;
  logic perm; // Mode and kind bit
  logic reach; // Local or global enable
  logic id_ok; // Privilege ID allow

  // Verdict from three independent gates
  always_comb begin
    unique case (c.kind)
      PMP_READ: perm = c.sup ? c.attr[ATTR_SR] : c.attr[ATTR_UR];
      PMP_WRITE: perm = c.sup ? c.attr[ATTR_SW] : c.attr[ATTR_UW];
      PMP_EXEC: perm = c.sup ? c.attr[ATTR_SX] : c.attr[ATTR_UX];
      default: perm = 1'b0;
    endcase
    reach = c.is_local ? c.attr[ATTR_LOCAL] : c.attr[ATTR_GLOBAL];
    id_ok = (c.priv == PRIV_CPU) ? c.attr[ATTR_CPU_PRIV_ALLOW]
                                 : c.attr[ATTR_MASTER_PRIV_ALLOW];
    c.allow = perm & reach & id_ok;
  end
endmodule : pmp_page_check

// file: rtl/pmp_pkg.sv
// Constants, types and register map of the page memory protection block
// What this block does
// - Level-1 data memory: sixteen 2KB protection pages
// - Level-1 program memory: sixteen 2KB protection pages
// - Level-2 port 0: thirty-two 128KB pages
// - Level-2 pages span 0x00800000 to 0x00BFFFFF
// - One attribute register per page, documented indices
// - Lowest index guards lowest page, ascending upward
// - Six independent user/supervisor read/write/execute bits
// - Separate local and global enable bits
// - CPU access local, DMA/other masters global
// - DMA transfers always count as global
// - CPU carries ID 0, others ID 1
// - Per-ID allow bits gate each requester
// - External controller accesses are never checked
package pmp_pkg;
  // Attribute word layout
  localparam int ATTR_W = 10;
  localparam int ATTR_UX = 0;
  localparam int ATTR_UW = 1;
  localparam int ATTR_UR = 2;
  localparam int ATTR_SX = 3;
  localparam int ATTR_SW = 4;
  localparam int ATTR_SR = 5;
  localparam int ATTR_LOCAL = 6;
  localparam int ATTR_GLOBAL = 7;
  localparam int ATTR_CPU_PRIV_ALLOW = 8;
  localparam int ATTR_MASTER_PRIV_ALLOW = 9;
  localparam logic [ATTR_W-1:0] ATTR_RST = 10'h3FF;
  // Memory map of the guarded memories
  localparam logic [31:0] L1D_BASE = 32'h00F00000;
  localparam logic [31:0] L1P_BASE = 32'h00E00000;
  localparam logic [31:0] L1_SPAN = 32'h00008000;
  localparam logic [31:0] L2_BASE = 32'h00800000;
  localparam logic [31:0] L2_LAST = 32'h00BFFFFF;
  localparam int L1_PAGES = 16;
  localparam int L1_IDX_W = 4;
  localparam int L1_PAGE_LSB = 11;
  localparam int L1_FIRST_IDX = 16;
  localparam int L2_PAGES = 32;
  localparam int L2_IDX_W = 5;
  localparam int L2_PAGE_LSB = 17;
  // Wishbone register map
  localparam int WB_ADR_W = 12;
  localparam int REG_IDX_LSB = 2;
  localparam int REG_IDX_W = 6;
  localparam int REG_BANK_LSB = 8;
  localparam int REG_BANK_W = 4;
  localparam logic [WB_ADR_W-1:0] REG_L2_ATTR = 12'h000;
  localparam logic [WB_ADR_W-1:0] REG_L1D_ATTR = 12'h100;
  localparam logic [WB_ADR_W-1:0] REG_L1P_ATTR = 12'h200;
  localparam logic [WB_ADR_W-1:0] REG_STATUS = 12'h300;
  localparam logic [WB_ADR_W-1:0] REG_MASK = 12'h304;
  localparam logic [WB_ADR_W-1:0] REG_FAULT_ADDR = 12'h308;
  localparam logic [WB_ADR_W-1:0] REG_FAULT_INFO = 12'h30C;
  // Status bits: local and global violations
  localparam int ST_W = 2;
  localparam int ST_LOCAL = 0;
  localparam int ST_GLOBAL = 1;
  // Fault info layout
  localparam int FINFO_W = 5;
  localparam int FI_KIND_LSB = 2;
  localparam int FI_SUP = 4;
  // Privilege identifiers
  localparam logic PRIV_CPU = 1'b0;
  localparam logic PRIV_MASTER = 1'b1;
  // Requesters
  typedef enum logic [1:0] {
    PMP_SRC_CPU, PMP_SRC_INTERNAL_DMA, PMP_SRC_ENHANCED_DMA, PMP_SRC_OTHER
  } pmp_src_t;
  // Access kinds
  typedef enum logic [1:0] {PMP_READ, PMP_WRITE, PMP_EXEC} pmp_kind_t;
  // Target memory of an address
  typedef enum logic [1:0] {PMP_EXT, PMP_L1D, PMP_L1P, PMP_L2} pmp_region_t;
endpackage : pmp_pkg

// file: rtl/pmp_top.sv
// Page memory protection for level-1 and level-2 memories, Wishbone slave
`timescale 1ns/1ps
module pmp_top (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pmp_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Access request
  input wire logic req_valid_i,
  input wire logic [31:0] req_addr_i,
  input wire pmp_pkg::pmp_kind_t req_kind_i,
  input wire pmp_pkg::pmp_src_t req_src_i,
  input wire logic req_sup_i,
  // Verdict, one cycle after the request
  output logic acc_valid_o,
  output logic acc_grant_o,
  output logic acc_deny_o,
  // Interrupt
  output logic irq_o
);
  import pmp_pkg::*;

  // All block state
  typedef struct packed {
    logic [L2_PAGES-1:0][ATTR_W-1:0] l2_attr; // Level-2 page attributes
    logic [L1_PAGES-1:0][ATTR_W-1:0] l1d_attr; // Level-1 data attributes
    logic [L1_PAGES-1:0][ATTR_W-1:0] l1p_attr; // Level-1 program attributes
    logic [ST_W-1:0] status; // Sticky violation flags
    logic [ST_W-1:0] mask; // Interrupt enables
    logic [31:0] fault_addr; // Address of last denied access
    logic [FINFO_W-1:0] fault_info; // Mode, kind and requester of last denied access
    logic acc_valid; // Verdict strobe
    logic acc_grant; // Access may proceed
    logic acc_deny; // Access suppressed
    logic irq; // Interrupt level
    logic wb_ack; // Bus answer
    logic [31:0] wb_dat; // Bus read data
  } pmp_state_t;

  pmp_state_t st; // Current state
  pmp_state_t next_st; // Next state
  pmp_region_t region; // Memory hit by the request
  logic [L1_IDX_W-1:0] l1_page; // Level-1 page of the request
  logic [L2_IDX_W-1:0] l2_page; // Level-2 page of the request
  logic is_local; // Request counts as local
  logic allow; // Final verdict
  logic [REG_BANK_W-1:0] bank; // Register bank of the bus address
  logic [REG_IDX_W-1:0] ridx; // Register index within the bank
  logic [L1_IDX_W-1:0] l1_ridx; // Level-1 array slot of the index
  logic l1_hit; // Index lies in the level-1 window
  logic l2_hit; // Index lies in the level-2 window
  logic bus_go; // Bus request taken this cycle
  logic [31:0] wmask; // Byte-lane write mask
  logic [31:0] l1d_end; // First byte past level-1 data
  logic [31:0] l1p_end; // First byte past level-1 program
  logic [31:0] fault_addr_q; // Recorded fault address
  pmp_chk_if chk (); // Checker bundle

  // Page permission checker
  pmp_page_check u_check (
    .c(chk.chk)
  );

  // Address decode of the request
  always_comb begin
    l1d_end = L1D_BASE + L1_SPAN;
    l1p_end = L1P_BASE + L1_SPAN;
    l1_page = req_addr_i[L1_PAGE_LSB +: L1_IDX_W];
    l2_page = req_addr_i[L2_PAGE_LSB +: L2_IDX_W];
    if (req_addr_i >= L1D_BASE && req_addr_i < l1d_end) begin
      region = PMP_L1D;
    end else if (req_addr_i >= L1P_BASE && req_addr_i < l1p_end) begin
      region = PMP_L1P;
    // level-2 span, ROM and RAM alike
    end else if (req_addr_i >= L2_BASE && req_addr_i <= L2_LAST) begin
      region = PMP_L2;
    end else begin
      region = PMP_EXT;
    end
  end

  // Checker inputs
  always_comb begin
    is_local = (req_src_i == PMP_SRC_CPU);
    // CPU is ID 0, others ID 1
    chk.priv = is_local ? PRIV_CPU : PRIV_MASTER;
    chk.is_local = is_local;
    chk.kind = req_kind_i;
    chk.sup = req_sup_i;
    unique case (region)
      PMP_L1D: chk.attr = st.l1d_attr[l1_page];
      PMP_L1P: chk.attr = st.l1p_attr[l1_page];
      PMP_L2: chk.attr = st.l2_attr[l2_page];
      // Unprotected target gets a fully open word
      PMP_EXT: chk.attr = ATTR_RST;
    endcase
    // external path never checked
    // Checker verdict ignored outside the windows
    allow = (region == PMP_EXT) || chk.allow;
  end

  // Bus address split
  always_comb begin
    bank = wb_adr_i[REG_BANK_LSB +: REG_BANK_W];
    ridx = wb_adr_i[REG_IDX_LSB +: REG_IDX_W];
    l1_ridx = ridx[L1_IDX_W-1:0];
    l1_hit = (ridx >= REG_IDX_W'(L1_FIRST_IDX))
             && (ridx < REG_IDX_W'(L1_FIRST_IDX + L1_PAGES));
    l2_hit = (ridx < REG_IDX_W'(L2_PAGES));
    bus_go = wb_cyc_i && wb_stb_i && !st.wb_ack;
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
    end
  end

  // Next state of the whole block
  always_comb begin
    next_st = st;
    next_st.wb_ack = bus_go;
    next_st.wb_dat = '0;
    // Bus reads, unmapped answer zero
    if (bus_go && !wb_we_i) begin
      if (bank == REG_L2_ATTR[REG_BANK_LSB +: REG_BANK_W] && l2_hit) begin
        next_st.wb_dat = 32'(st.l2_attr[ridx[L2_IDX_W-1:0]]);
      end else if (bank == REG_L1D_ATTR[REG_BANK_LSB +: REG_BANK_W] && l1_hit) begin
        next_st.wb_dat = 32'(st.l1d_attr[l1_ridx]);
      end else if (bank == REG_L1P_ATTR[REG_BANK_LSB +: REG_BANK_W] && l1_hit) begin
        next_st.wb_dat = 32'(st.l1p_attr[l1_ridx]);
      end else if (wb_adr_i == REG_STATUS) begin
        next_st.wb_dat = 32'(st.status);
        next_st.status = '0;
      end else if (wb_adr_i == REG_MASK) begin
        next_st.wb_dat = 32'(st.mask);
      end else if (wb_adr_i == REG_FAULT_ADDR) begin
        next_st.wb_dat = st.fault_addr;
      end else if (wb_adr_i == REG_FAULT_INFO) begin
        next_st.wb_dat = 32'(st.fault_info);
      end
    end
    // Bus writes with byte lanes
    if (bus_go && wb_we_i) begin
      if (bank == REG_L2_ATTR[REG_BANK_LSB +: REG_BANK_W] && l2_hit) begin
        next_st.l2_attr[ridx[L2_IDX_W-1:0]] = ATTR_W'(
          (32'(st.l2_attr[ridx[L2_IDX_W-1:0]]) & ~wmask) | (wb_dat_i & wmask));
      end else if (bank == REG_L1D_ATTR[REG_BANK_LSB +: REG_BANK_W] && l1_hit) begin
        next_st.l1d_attr[l1_ridx] = ATTR_W'(
          (32'(st.l1d_attr[l1_ridx]) & ~wmask) | (wb_dat_i & wmask));
      end else if (bank == REG_L1P_ATTR[REG_BANK_LSB +: REG_BANK_W] && l1_hit) begin
        next_st.l1p_attr[l1_ridx] = ATTR_W'(
          (32'(st.l1p_attr[l1_ridx]) & ~wmask) | (wb_dat_i & wmask));
      end else if (wb_adr_i == REG_MASK && wb_sel_i[0]) begin
        next_st.mask = wb_dat_i[ST_W-1:0];
      end
    end
    next_st.acc_valid = req_valid_i;
    next_st.acc_grant = req_valid_i && allow;
    next_st.acc_deny = req_valid_i && !allow;
    if (req_valid_i && !allow) begin
      // Set wins over a clearing read
      if (is_local) begin
        next_st.status[ST_LOCAL] = 1'b1;
      end else begin
        next_st.status[ST_GLOBAL] = 1'b1;
      end
      next_st.fault_addr = req_addr_i;
      next_st.fault_info = {req_sup_i, req_kind_i, req_src_i};
    end
    // Level interrupt from masked status
    next_st.irq = |(next_st.status & next_st.mask);
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      // Every page opens fully after reset
      st.l2_attr <= {L2_PAGES{ATTR_RST}};
      st.l1d_attr <= {L1_PAGES{ATTR_RST}};
      st.l1p_attr <= {L1_PAGES{ATTR_RST}};
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign wb_dat_o = st.wb_dat;
  assign wb_ack_o = st.wb_ack;
  assign acc_valid_o = st.acc_valid;
  assign acc_grant_o = st.acc_grant;
  assign acc_deny_o = st.acc_deny;
  assign irq_o = st.irq;
  // Fault address seen by the checks
  assign fault_addr_q = st.fault_addr;

  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Bus answers one cycle after the request
  bus_ack_a: assert property (bus_go |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle after request");
  l1d_page_a: assert property (req_addr_i >= L1D_BASE && req_addr_i < l1d_end
      |-> region == PMP_L1D && l1_page == req_addr_i[14:11])
    else $error("level-1 data page decode wrong");
  l1p_page_a: assert property (req_addr_i >= L1P_BASE && req_addr_i < l1p_end
      |-> region == PMP_L1P)
    else $error("level-1 program page decode wrong");
  l2_span_a: assert property (req_addr_i >= L2_BASE && req_addr_i <= L2_LAST
      |-> region == PMP_L2 && l2_page == req_addr_i[21:17])
    else $error("level-2 page decode wrong");
  ext_pass_a: assert property (req_valid_i && region == PMP_EXT
      |=> acc_grant_o && !acc_deny_o)
    else $error("external access not passed");
  dma_global_a: assert property (req_valid_i && region != PMP_EXT
      && req_src_i inside {PMP_SRC_INTERNAL_DMA, PMP_SRC_ENHANCED_DMA}
      && !chk.attr[ATTR_GLOBAL] |=> acc_deny_o)
    else $error("DMA access not treated as global");
  master_id_a: assert property (req_valid_i && region != PMP_EXT
      && req_src_i != PMP_SRC_CPU
      && !chk.attr[ATTR_MASTER_PRIV_ALLOW] |=> acc_deny_o)
    else $error("master privilege bit ignored");
  // CPU gated by ID 0 bit
  cpu_id_a: assert property (req_valid_i && region != PMP_EXT
      && req_src_i == PMP_SRC_CPU
      && !chk.attr[ATTR_CPU_PRIV_ALLOW] |=> acc_deny_o)
    else $error("CPU privilege bit ignored");
  sup_write_a: assert property (req_valid_i && region != PMP_EXT
      && req_sup_i && req_kind_i == PMP_WRITE
      && !chk.attr[ATTR_SW] |=> acc_deny_o)
    else $error("supervisor write bit ignored");
  sup_read_a: assert property (req_valid_i && region != PMP_EXT
      && req_sup_i && req_kind_i == PMP_READ
      && !chk.attr[ATTR_SR] |=> acc_deny_o)
    else $error("supervisor read bit ignored");
  sup_exec_a: assert property (req_valid_i && region != PMP_EXT
      && req_sup_i && req_kind_i == PMP_EXEC
      && !chk.attr[ATTR_SX] |=> acc_deny_o)
    else $error("supervisor execute bit ignored");
  user_read_a: assert property (req_valid_i && region != PMP_EXT
      && !req_sup_i && req_kind_i == PMP_READ
      && !chk.attr[ATTR_UR] |=> acc_deny_o)
    else $error("user read bit ignored");
  user_exec_a: assert property (req_valid_i && region != PMP_EXT
      && !req_sup_i && req_kind_i == PMP_EXEC
      && !chk.attr[ATTR_UX] |=> acc_deny_o)
    else $error("user execute bit ignored");
  local_en_a: assert property (req_valid_i && region != PMP_EXT
      && req_src_i == PMP_SRC_CPU
      && !chk.attr[ATTR_LOCAL] |=> acc_deny_o)
    else $error("local enable bit ignored");
  global_en_a: assert property (req_valid_i && region != PMP_EXT
      && req_src_i != PMP_SRC_CPU
      && !chk.attr[ATTR_GLOBAL] |=> acc_deny_o)
    else $error("global enable bit ignored");
  open_page_a: assert property (req_valid_i && region != PMP_EXT
      && chk.attr == ATTR_RST && req_kind_i inside {PMP_READ, PMP_WRITE, PMP_EXEC} |=> acc_grant_o)
    else $error("open page access denied");
  verdict_time_a: assert property (req_valid_i |=> acc_valid_o)
    else $error("no verdict after request");
  no_verdict_a: assert property (!req_valid_i |=> !acc_valid_o)
    else $error("verdict without request");
  verdict_pair_a: assert property (acc_valid_o |-> acc_grant_o != acc_deny_o)
    else $error("verdict not exactly grant or deny");
  verdict_idle_a: assert property (!acc_valid_o |-> !acc_grant_o && !acc_deny_o)
    else $error("grant or deny without verdict");
  fault_rec_a: assert property (req_valid_i && !allow |=> acc_deny_o
      && fault_addr_q == $past(req_addr_i) && (st.status != '0)
      ##1 (irq_o == |(st.status & st.mask)))
    else $error("denied access not recorded");
  fault_hold_a: assert property (!(req_valid_i && !allow) |=> $stable(fault_addr_q))
    else $error("fault address changed without denial");
  irq_level_a: assert property (irq_o == |(st.status & st.mask))
    else $error("interrupt level wrong");
  status_clear_a: assert property (bus_go && !wb_we_i && wb_adr_i == REG_STATUS
      && !(req_valid_i && !allow) |=> st.status == '0)
    else $error("status not cleared by read");
  ext_quiet_a: assert property (req_valid_i && region == PMP_EXT
      |=> $stable(fault_addr_q) && !acc_deny_o)
    else $error("external access recorded as fault");
  // level-2 attribute write on all byte lanes lands in its page
  attr_write_a: assert property (bus_go && wb_we_i && wb_sel_i == 4'hF && l2_hit
      && bank == REG_L2_ATTR[REG_BANK_LSB +: REG_BANK_W]
      |=> st.l2_attr[$past(ridx[L2_IDX_W-1:0])] == $past(wb_dat_i[ATTR_W-1:0]))
    else $error("attribute write lost");
  l1_gap_a: assert property (bus_go && !wb_we_i && !l1_hit
      && bank == REG_L1D_ATTR[REG_BANK_LSB +: REG_BANK_W] |=> wb_dat_o == '0)
    else $error("unmapped level-1 index answered");
  // Mask written through byte lane 0
  mask_write_a: assert property (bus_go && wb_we_i && wb_adr_i == REG_MASK && wb_sel_i[0]
      |=> st.mask == $past(wb_dat_i[ST_W-1:0]))
    else $error("mask write lost");
  // Ack only after a taken request
  ack_cause_a: assert property (wb_ack_o |-> $past(bus_go))
    else $error("ack without request");
  // Read data zero outside ack
  read_zero_a: assert property (!wb_ack_o |-> wb_dat_o == '0)
    else $error("read data outside ack cycle");

  // Main scenarios
  grant_c: cover property (req_valid_i ##1 acc_grant_o);
  deny_c: cover property (req_valid_i ##1 acc_deny_o ##1 irq_o);
  clear_c: cover property (bus_go && !wb_we_i && wb_adr_i == REG_STATUS
      && st.status != '0);
  exec_c: cover property (req_valid_i && req_kind_i == PMP_EXEC ##1 acc_grant_o);
  dma_deny_c: cover property (req_valid_i && req_src_i != PMP_SRC_CPU ##1 acc_deny_o);
endmodule : pmp_top
